// >>> rtl/tss_defs.vh
// Operation
// - Six per-lane tristate source bits; bit index selects the lane slice.
// - Direct mode: lane tristate output follows fabric tristate bit combinationally.
// - At width 2 only direct mode; write-enable mode is not selectable.
// - Write-enable mode: invert, serialize and broadcast vector to selected lanes.
// - Each write-enable bit sent covers two consecutive serial unit intervals; width 4 sends bits 0 and 1 only.
// - Serialized write-enable tristate stream aligned with lane serial data at zero delay; each delay step lags it one unit interval.
// - Lane takes only its selected tristate source and drives its output.
// - Write-enable path has one fabric word cycle more latency than data.
// - Lane x parallel word of eight bits goes to serial output bit x.
// - Order: 8:1 bits 0..7, 4:1 bits 0..3, 2:1 bit 0 then 4.
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH

`define TSS_ADDR_SRC 4'h0
`define TSS_ADDR_WIDTH 4'h1
`define TSS_ADDR_TDLY 4'h2
`define TSS_ADDR_STAT 4'h3

`define TSS_WIDTH_8 2'h0
`define TSS_WIDTH_4 2'h1
`define TSS_WIDTH_2 2'h2

`define TSS_SRC_RST 6'h00
`define TSS_WIDTH_RST 2'h0
`define TSS_TDLY_RST 3'h0

`define TSS_LAST_8 3'h7
`define TSS_LAST_4 3'h3
`define TSS_LAST_2 3'h1

`define TSS_STAT_PH_LSB 0
`define TSS_STAT_WIDTH_LSB 3
`define TSS_STAT_WEBAD_BIT 5

`endif

// >>> rtl/tss_lane_ser.v
`include "tss_defs.vh"

module tss_lane_ser (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Control
  input wire i_load,
  input wire [1:0] i_width,
  input wire [2:0] i_phase,
  // Data
  input wire [7:0] i_word,
  output reg o_serial
);

  reg [7:0] word_reg;
  reg [7:0] word_next;
  reg [2:0] idx;

  // Whole word is kept: at a width change it loads under the old width,
  // so a mask here would drop bits; the index alone never picks unused bits
  always @* begin
    word_next = i_word;
  end

  always @* begin
    if (i_width == `TSS_WIDTH_8) begin
      idx = i_phase;
    end else if (i_width == `TSS_WIDTH_4) begin
      idx = {1'b0, i_phase[1:0]};
    end else begin
      idx = {i_phase[0], 2'h0};
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      word_reg <= 8'h00;
      o_serial <= 1'b0;
    end else begin
      if (i_load) begin
        word_reg <= word_next;
      end
      o_serial <= word_reg[idx];
    end
  end

endmodule // tss_lane_ser

// >>> rtl/tss_tdly.v
`include "tss_defs.vh"

module tss_tdly #(
  parameter DEPTH = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Stream
  input wire i_t,
  input wire [2:0] i_dly,
  output wire o_t
);

  reg [DEPTH-1:0] tap_reg;
  wire [DEPTH:0] taps;

  assign taps = {tap_reg, i_t};
  // Tap 0 is the undelayed stream, so a zero setting adds no latency
  assign o_t = taps[i_dly];

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      tap_reg <= {DEPTH{1'b1}};
    end else begin
      tap_reg <= taps[DEPTH-1:0];
    end
  end

endmodule // tss_tdly

// >>> rtl/tss_top.v
// The address-and-strobe port and the register offsets were chosen for this implementation.
`include "tss_defs.vh"

module tss_top #(
  parameter LANES = 6,
  parameter WEN_W = 4
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Fabric transmit side
  input wire [8*LANES-1:0] i_parallel_tx_word,
  input wire [LANES-1:0] i_t_direct,
  input wire [WEN_W-1:0] i_shared_write_enable_vector,
  output reg o_word_load,
  // Pin side
  output wire [LANES-1:0] o_serial_data_output,
  output wire [LANES-1:0] o_t_out
);

  reg [LANES-1:0] tristate_source_select_reg;
  reg [1:0] width_cfg_reg;
  reg [2:0] tdly_reg;
  reg [1:0] width_act_reg;
  reg [1:0] width_next;
  reg [2:0] ph_reg;
  reg [2:0] ph_next;
  reg [2:0] last_next;
  reg load_next;
  reg [WEN_W-1:0] we_stage_reg;
  reg [WEN_W-1:0] we_cur_reg;
  reg t_ser_reg;
  reg [7:0] rdata_next;
  wire [LANES-1:0] src_eff;
  wire t_we;
  wire we_bad;

  // Register writes; the delay line has no other update path
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      tristate_source_select_reg <= `TSS_SRC_RST;
      width_cfg_reg <= `TSS_WIDTH_RST;
      tdly_reg <= `TSS_TDLY_RST;
    end else if (i_wr) begin
      if (i_addr == `TSS_ADDR_SRC) begin
        tristate_source_select_reg <= i_wdata[LANES-1:0];
      end else if (i_addr == `TSS_ADDR_WIDTH) begin
        if (i_wdata[1:0] != 2'h3) begin
          width_cfg_reg <= i_wdata[1:0];
        end
      end else if (i_addr == `TSS_ADDR_TDLY) begin
        tdly_reg <= i_wdata[2:0];
      end
    end
  end

  // Width 2 forces every lane to direct mode whatever software wrote
  assign we_bad = (width_act_reg == `TSS_WIDTH_2);
  assign src_eff = we_bad ? {LANES{1'b0}} : tristate_source_select_reg;

  // Read data live only in the cycle after the strobe
  always @* begin
    rdata_next = 8'h00;
    if (i_rd) begin
      if (i_addr == `TSS_ADDR_SRC) begin
        rdata_next[LANES-1:0] = tristate_source_select_reg;
      end else if (i_addr == `TSS_ADDR_WIDTH) begin
        rdata_next[1:0] = width_cfg_reg;
      end else if (i_addr == `TSS_ADDR_TDLY) begin
        rdata_next[2:0] = tdly_reg;
      end else if (i_addr == `TSS_ADDR_STAT) begin
        rdata_next[`TSS_STAT_PH_LSB+2:`TSS_STAT_PH_LSB] = ph_reg;
        rdata_next[`TSS_STAT_WIDTH_LSB+1:`TSS_STAT_WIDTH_LSB] = width_act_reg;
        rdata_next[`TSS_STAT_WEBAD_BIT] = we_bad & (|tristate_source_select_reg);
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

  // Word timing; width changes only take effect at a word boundary
  always @* begin
    width_next = o_word_load ? width_cfg_reg : width_act_reg;
    ph_next = o_word_load ? 3'h0 : ph_reg + 3'h1;
    if (width_next == `TSS_WIDTH_8) begin
      last_next = `TSS_LAST_8;
    end else if (width_next == `TSS_WIDTH_4) begin
      last_next = `TSS_LAST_4;
    end else begin
      last_next = `TSS_LAST_2;
    end
    load_next = (ph_next == last_next);
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      width_act_reg <= `TSS_WIDTH_RST;
      ph_reg <= 3'h0;
      o_word_load <= 1'b0;
    end else begin
      width_act_reg <= width_next;
      ph_reg <= ph_next;
      o_word_load <= load_next;
    end
  end

  // Extra stage on the write-enable path delays it by one word cycle
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      we_stage_reg <= {WEN_W{1'b1}};
      we_cur_reg <= {WEN_W{1'b1}};
      t_ser_reg <= 1'b1;
    end else begin
      if (o_word_load) begin
        we_stage_reg <= ~i_shared_write_enable_vector;
        we_cur_reg <= we_stage_reg;
      end
      // Same register depth as the lane output flop keeps the two aligned
      t_ser_reg <= we_cur_reg[ph_reg[2:1]];
    end
  end

  tss_tdly #(
    .DEPTH(8)
  ) u_tdly (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_t(t_ser_reg),
    .i_dly(tdly_reg),
    .o_t(t_we)
  );

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      tss_lane_ser u_ser (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(o_word_load),
        .i_width(width_act_reg),
        .i_phase(ph_reg),
        .i_word(i_parallel_tx_word[8*g+7:8*g]),
        .o_serial(o_serial_data_output[g])
      );
      // Direct mode is deliberately unregistered and so unaligned to data
      assign o_t_out[g] = src_eff[g] ? t_we : i_t_direct[g];
    end
  endgenerate

endmodule // tss_top

// >>> sim/tss_fabric.sv
module tss_fabric (
  input wire i_clk, i_rst_n, i_load,
  output logic [47:0] o_word,
  output logic [3:0] o_wen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg = 8'h00;
  always @(posedge i_clk) cnt_reg <= !i_rst_n ? 8'h00 : cnt_reg + {7'h00, i_load};
  // Vector leads the data word it governs by one word slot
  assign o_wen = cnt_reg[3:0] ^ 4'h6;
  // Lanes carry different words so a lane swap shows
  for (genvar x = 0; x < 6; x++) assign o_word[8*x +: 8] = {cnt_reg[4:0], 3'(x)} * 8'h3B;
endmodule // tss_fabric

// >>> sim/tss_top_monitor.sv
module tss_mon #(parameter LANES = 6, parameter WEN_W = 4) (
  input wire i_clk, i_rst_n, i_wr, i_rd, o_word_load,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata, o_rdata,
  input wire [8*LANES-1:0] i_parallel_tx_word,
  input wire [LANES-1:0] i_t_direct, o_serial_data_output, o_t_out,
  input wire [WEN_W-1:0] i_shared_write_enable_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [5:0] sel_reg;
  reg [1:0] wid_reg;
  wire [5:0] we_t = o_t_out & sel_reg;
  wire v0 = i_shared_write_enable_vector[0];
  wire [5:0] lsb;
  for (genvar g = 0; g < 6; g++) assign lsb[g] = i_parallel_tx_word[8*g];
  // Shadow settings; width 3 is refused by the design
  always @(posedge i_clk) sel_reg <= !i_rst_n ? 6'h00 : i_wr && i_addr == 4'h0 ? i_wdata[5:0] : sel_reg;
  always @(posedge i_clk) wid_reg <= !i_rst_n ? 2'h0
    : i_wr && i_addr == 4'h1 && i_wdata[1:0] != 2'h3 ? i_wdata[1:0] : wid_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RD_SEL: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == {2'h0, sel_reg})
    else $error("select readback");
  AST_RD_WID: assert property (i_rd && i_addr == 4'h1 |=> o_rdata == {6'h00, wid_reg})
    else $error("width readback");
  AST_LD_GAP: assert property (o_word_load |=> !o_word_load)
    else $error("load gap");
  AST_LD_8: assert property (o_word_load && wid_reg == 2'h0 && $past(wid_reg, 9) == 2'h0
    |-> ##8 o_word_load) else $error("load period");
  AST_SER: assert property (o_word_load |-> ##2 o_serial_data_output == $past(lsb, 2))
    else $error("first bit");
  AST_DIR: assert property ((~sel_reg & (o_t_out ^ i_t_direct)) == 6'h00)
    else $error("direct tristate");
  AST_BC: assert property (wid_reg != 2'h2 && $past(wid_reg, 9) != 2'h2
    |-> we_t == 6'h00 || we_t == sel_reg) else $error("broadcast");
  AST_WE: assert property (o_word_load && wid_reg == 2'h0 && $past(wid_reg, 9) == 2'h0
    && sel_reg != 6'h00 |-> ##10 we_t == (sel_reg & {6{!$past(v0, 10)}})
    ##1 we_t == (sel_reg & {6{!$past(v0, 11)}})) else $error("write-enable stream");
endmodule // tss_mon
bind tss_top tss_mon #(.LANES(LANES), .WEN_W(WEN_W)) u_mon (.*);

// >>> sim/tss_top_tb.sv
module tss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0, o_word_load;
  logic [3:0] i_addr = 4'h0, i_shared_write_enable_vector;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic [5:0] i_t_direct = 6'h2A, o_serial_data_output, o_t_out;
  logic [47:0] i_parallel_tx_word;
  int err_total = 0, n_tests = 0;
  tss_top DUT (.*);
  tss_fabric u_fab (.i_clk, .i_rst_n, .i_load(o_word_load), .o_word(i_parallel_tx_word),
    .o_wen(i_shared_write_enable_vector));
  initial forever #2 i_clk = ~i_clk;
  task automatic chk(input string s, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, m, input string s);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    @(posedge i_clk);
    chk(s, e, o_rdata & m);
  endtask
  task automatic t_reg;
    rd(4'h0, 8'h00, 8'hFF, "select");
    rd(4'hF, 8'h00, 8'hFF, "unmapped");
    wr(4'h0, 8'h15);
    rd(4'h0, 8'h15, 8'hFF, "select");
    wr(4'h1, 8'h03);
    rd(4'h1, 8'h00, 8'hFF, "width");
  endtask
  task automatic t_stream(input logic [5:0] s, input logic [1:0] w, input int dl);
    logic [47:0] d;
    logic [3:0] v;
    logic [5:0] e, se;
    logic [2:0] p;
    int n, b;
    wr(4'h0, {2'h0, s});
    wr(4'h1, {6'h00, w});
    // Pending write-enable checks of the old width expire before the delay moves
    repeat (10) @(posedge i_clk);
    wr(4'h2, 8'(dl));
    rd(4'h2, 8'(dl), 8'hFF, "delay");
    n = 8 >> w;
    se = w == 2'h2 ? 6'h00 : s;
    p = 3'((1 + dl) % n);
    // Let the new width settle at a word boundary first
    repeat (3) do @(posedge i_clk); while (o_word_load !== 1'h1);
    d = i_parallel_tx_word;
    v = i_shared_write_enable_vector;
    for (int c = 1; c < 2 * n + 2 + dl; c++) begin
      // Toggling each cycle exposes a registered direct path
      i_t_direct <= ~i_t_direct;
      @(posedge i_clk);
      b = n == 2 && c == 3 ? 4 : c - 2;
      for (int x = 0; x < 6; x++) e[x] = d[8 * x + b];
      if (c > 1 && c < n + 2) begin
        chk("serial", {2'h0, e}, {2'h0, o_serial_data_output});
      end
      e = (se & {6{~v[(c - n - 2 - dl) / 2]}}) | (~se & i_t_direct);
      if (c > n + 1 + dl) begin
        chk("tristate", {2'h0, e}, {2'h0, o_t_out});
      end
    end
    rd(4'h3, {2'h0, (w == 2'h2 && s != 6'h00), w, p}, 8'hFF, "status");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_reg;
    t_stream(6'h00, 2'h0, 0);
    t_stream(6'h00, 2'h1, 0);
    t_stream(6'h00, 2'h2, 0);
    t_stream(6'h3F, 2'h2, 0);
    t_stream(6'h15, 2'h0, 0);
    t_stream(6'h3F, 2'h1, 3);
    finish_test;
  end
  // Run needs about 300 cycles; this cuts off a missing load strobe
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
endmodule // tss_top_tb
